// ### hw/gpio_level_pwm_encoder.sv
// level pwm encoder for general purpose pins 0 and 1 with a wishbone slave
module gpio_level_pwm_encoder #(
  parameter int PINS = 2
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // missing host detect from the device core
  input wire logic missing_host_detect_i,
  // pins
  output logic [1:0] pin_out_o,
  output logic [1:0] pin_oe_o
);
  // count registers, one low-level and one high-level pair per pin
  logic [15:0] ll_cfg_r [PINS];
  logic [15:0] lh_cfg_r [PINS];
  // own control register: direction, output data, pin 0 source
  logic [15:0] ctrl_r;
  // bus side state
  logic ack_r;
  logic [31:0] rdata_r;
  logic req;
  logic wr_req;
  logic [7:0] idx;
  logic idx_ok;
  logic [15:0] lane_mask;
  logic [15:0] rd_word;
  // channel results
  logic [PINS-1:0] ch_pwm;
  logic [PINS-1:0] ch_phase;
  logic [PINS-1:0] dir;
  logic [PINS-1:0] out_data;
  logic src0_gpio;
  logic [1:0] pin_out_r;
  logic [1:0] pin_oe_r;

  // a new request is taken once; ack drops the cycle after it is given
  assign req = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr_req = req && wb_we_i;
  assign idx = wb_adr_i[9:2];
  // upper address bits must be zero for a hit
  assign idx_ok = (wb_adr_i[31:10] == 22'h000000);

  // byte lanes 0 and 1 carry the 16-bit registers
  assign lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // control fields unpacked for the pin logic
  assign dir = ctrl_r[pwm_enc_pkg::CTRL_DIR_LSB +: PINS];
  assign out_data = ctrl_r[pwm_enc_pkg::CTRL_DATA_LSB +: PINS];
  assign src0_gpio = ctrl_r[pwm_enc_pkg::CTRL_SRC0];

  // merge a write into a register through lanes and a writable mask
  function automatic logic [15:0] merge(
    input logic [15:0] old,
    input logic [31:0] wdat,
    input logic [15:0] lanes,
    input logic [15:0] wmask
  );
    logic [15:0] en;
    en = lanes & wmask;
    merge = (old & ~en) | (wdat[15:0] & en);
  endfunction : merge

  // wishbone acknowledge, one cycle after the request is seen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req;
    end
  end

  // pin 0 low-level register, holds the pin 0 unit selector as well
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ll_cfg_r[0] <= pwm_enc_pkg::LL_RESET;
    end else if (wr_req && idx_ok && idx == pwm_enc_pkg::IDX_PIN0_LL) begin
      ll_cfg_r[0] <= merge(ll_cfg_r[0], wb_dat_i, lane_mask, 16'hFFFF);
    end
  end

  // pin 0 high-level register, selector bits stay zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lh_cfg_r[0] <= pwm_enc_pkg::LH_RESET;
    end else if (wr_req && idx_ok && idx == pwm_enc_pkg::IDX_PIN0_LH) begin
      lh_cfg_r[0] <= merge(lh_cfg_r[0], wb_dat_i, lane_mask, pwm_enc_pkg::LH_WMASK);
    end
  end

  // pin 1 low-level register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ll_cfg_r[1] <= pwm_enc_pkg::LL_RESET;
    end else if (wr_req && idx_ok && idx == pwm_enc_pkg::IDX_PIN1_LL) begin
      ll_cfg_r[1] <= merge(ll_cfg_r[1], wb_dat_i, lane_mask, 16'hFFFF);
    end
  end

  // pin 1 high-level register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lh_cfg_r[1] <= pwm_enc_pkg::LH_RESET;
    end else if (wr_req && idx_ok && idx == pwm_enc_pkg::IDX_PIN1_LH) begin
      lh_cfg_r[1] <= merge(lh_cfg_r[1], wb_dat_i, lane_mask, pwm_enc_pkg::LH_WMASK);
    end
  end

  // control register: direction, output data and pin 0 source
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= pwm_enc_pkg::CTRL_RESET;
    end else if (wr_req && idx_ok && idx == pwm_enc_pkg::IDX_CTRL) begin
      ctrl_r <= merge(ctrl_r, wb_dat_i, lane_mask, pwm_enc_pkg::CTRL_WMASK);
    end
  end

  // read multiplexer; unmapped indices answer zero but still ack
  always_comb begin
    rd_word = 16'h0000;
    if (idx_ok) begin
      case (idx)
        pwm_enc_pkg::IDX_PIN0_LL: rd_word = ll_cfg_r[0];
        pwm_enc_pkg::IDX_PIN0_LH: rd_word = lh_cfg_r[0] & pwm_enc_pkg::LH_WMASK;
        pwm_enc_pkg::IDX_PIN1_LL: rd_word = ll_cfg_r[1];
        pwm_enc_pkg::IDX_PIN1_LH: rd_word = lh_cfg_r[1] & pwm_enc_pkg::LH_WMASK;
        pwm_enc_pkg::IDX_CTRL: rd_word = ctrl_r;
        pwm_enc_pkg::IDX_STATUS: rd_word = {10'h000, pin_oe_r, ch_phase, pin_out_r};
        default: rd_word = 16'h0000;
      endcase
    end
  end

  // read data captured with the request so it stands alongside ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_r <= 32'h00000000;
    end else if (req && !wb_we_i) begin
      rdata_r <= {16'h0000, rd_word};
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;

  // one channel per pin, each fed the pair chosen by its logical level
  for (genvar p = 0; p < PINS; p++) begin : g_pin
    pwm_cfg_if ch_if ();
    logic gp_level;
    logic gp_enable;

    // pin 0 as output only runs pwm on the general purpose source
    if (p == 0) begin : g_src
      assign gp_enable = dir[p] && src0_gpio;
    end else begin : g_nosrc
      assign gp_enable = dir[p];
    end

    // level comes from the output data bit of a general purpose output
    assign gp_level = gp_enable && out_data[p];

    assign ch_if.enable = gp_enable;
    assign ch_if.level = gp_level;
    // the high-level pair borrows the selector of the low-level register
    assign ch_if.unit_sel = ll_cfg_r[p][pwm_enc_pkg::SEL_MSB:pwm_enc_pkg::SEL_LSB];
    // pick the pair for the current logical level
    assign ch_if.high_cnt = gp_level ?
      lh_cfg_r[p][pwm_enc_pkg::HC_MSB:pwm_enc_pkg::HC_LSB] :
      ll_cfg_r[p][pwm_enc_pkg::HC_MSB:pwm_enc_pkg::HC_LSB];
    assign ch_if.low_cnt = gp_level ?
      lh_cfg_r[p][pwm_enc_pkg::LC_MSB:pwm_enc_pkg::LC_LSB] :
      ll_cfg_r[p][pwm_enc_pkg::LC_MSB:pwm_enc_pkg::LC_LSB];
    assign ch_pwm[p] = ch_if.pwm;
    assign ch_phase[p] = ch_if.phase_high;

    pwm_channel u_chan (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cfg(ch_if.chan)
    );
  end

  // pin 0 drive: detect signal registered for source 0b, else the pwm waveform
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_out_r[0] <= 1'b0;
      pin_oe_r[0] <= 1'b0;
    end else begin
      pin_oe_r[0] <= dir[0];
      if (!dir[0]) begin
        pin_out_r[0] <= 1'b0;
      end else if (!src0_gpio) begin
        pin_out_r[0] <= missing_host_detect_i;
      end else begin
        pin_out_r[0] <= ch_pwm[0];
      end
    end
  end

  // pin 1 drive: pwm waveform only while configured as output
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_out_r[1] <= 1'b0;
      pin_oe_r[1] <= 1'b0;
    end else begin
      pin_oe_r[1] <= dir[1];
      pin_out_r[1] <= dir[1] && ch_pwm[1];
    end
  end

  // outputs come straight from flip-flops
  assign pin_out_o = pin_out_r;
  assign pin_oe_o = pin_oe_r;
endmodule : gpio_level_pwm_encoder

// ### hw/pwm_enc_pkg.sv
// constants, register map and field layout of the level pwm encoder
// Operation
// - each pin's time unit is 16, 64, 256 or 1024 clocks for selector 00b, 01b, 10b, 11b.
// - one selected time unit serves both the pin waveform and the encoder of that pin.
// - a pin makes pwm drive only while it is set as an output.
// - one pwm cycle lasts high count plus low count, times the time unit.
// - each cycle holds the pin high for high count times the time unit.
// - each cycle holds the pin low for low count times the time unit.
// - a high count of zero gives a constant low for that logical level.
// - a zero low count with a nonzero high count gives a constant high for that level.
// - both counts zero gives a constant low for that level.
// - every pin keeps one count pair for logical low and another for logical high.
// - high count sits at bits 13:7, low count at 6:0 and the unit selector at 15:14.
// - after reset the high-level pair is 1111111b/0 and the low-level pair is 0/1111111b.
// - the logical level is the pin's output data bit when it is a general purpose output.
// - pin 0 as output carries missing_host_detect for source 0b and general data for 1b.
package pwm_enc_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_PIN0_LL = 8'h4F;
  localparam logic [7:0] IDX_PIN0_LH = 8'h50;
  localparam logic [7:0] IDX_PIN1_LL = 8'h51;
  localparam logic [7:0] IDX_PIN1_LH = 8'h52;
  localparam logic [7:0] IDX_CTRL = 8'h60;
  localparam logic [7:0] IDX_STATUS = 8'h61;
  // field layout of the count registers
  localparam int SEL_MSB = 15;
  localparam int SEL_LSB = 14;
  localparam int HC_MSB = 13;
  localparam int HC_LSB = 7;
  localparam int LC_MSB = 6;
  localparam int LC_LSB = 0;
  localparam int CNT_W = 7;
  // reset values
  localparam logic [15:0] LL_RESET = 16'h007F;
  localparam logic [15:0] LH_RESET = 16'h3F80;
  localparam logic [15:0] LH_WMASK = 16'h3FFF;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  // control register bits
  localparam int CTRL_DIR_LSB = 0;
  localparam int CTRL_DATA_LSB = 2;
  localparam int CTRL_SRC0 = 4;
  localparam logic [15:0] CTRL_WMASK = 16'h001F;
  // time unit in main clock periods per selector code
  localparam logic [10:0] UNIT_SEL0 = 11'h010;
  localparam logic [10:0] UNIT_SEL1 = 11'h040;
  localparam logic [10:0] UNIT_SEL2 = 11'h100;
  localparam logic [10:0] UNIT_SEL3 = 11'h400;
endpackage : pwm_enc_pkg

// ### hw/pwm_cfg_if.sv
// carrier between the register block and one pwm channel
interface pwm_cfg_if;
  logic enable;
  logic level;
  logic [1:0] unit_sel;
  logic [6:0] high_cnt;
  logic [6:0] low_cnt;
  logic pwm;
  logic phase_high;
  modport ctrl (output enable, level, unit_sel, high_cnt, low_cnt, input pwm, phase_high);
  modport chan (input enable, level, unit_sel, high_cnt, low_cnt, output pwm, phase_high);
endinterface : pwm_cfg_if

// ### hw/pwm_channel.sv
// one pin's pwm waveform generator with its own time unit prescaler
module pwm_channel (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // configuration and waveform
  pwm_cfg_if.chan cfg
);
  logic [9:0] pre_r;
  logic [6:0] cnt_r;
  logic phase_r;
  logic level_r;
  logic enable_r;
  logic pwm_r;
  logic [10:0] unit;
  logic tick;
  logic restart;

  // selector to clock periods, one unit for waveform and encoder alike
  always_comb begin
    case (cfg.unit_sel)
      2'b00: unit = pwm_enc_pkg::UNIT_SEL0;
      2'b01: unit = pwm_enc_pkg::UNIT_SEL1;
      2'b10: unit = pwm_enc_pkg::UNIT_SEL2;
      default: unit = pwm_enc_pkg::UNIT_SEL3;
    endcase
  end

  // a level flip or a fresh enable starts the cycle over
  assign restart = (cfg.level != level_r) || (cfg.enable && !enable_r);
  assign tick = ({1'b0, pre_r} == unit - 11'h001);

  // history of level and enable for restart detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_r <= 1'b0;
      enable_r <= 1'b0;
    end else begin
      level_r <= cfg.level;
      enable_r <= cfg.enable;
    end
  end

  // prescaler: counts clock periods inside one time unit
  always_ff @(posedge clk_i) begin
    if (rst_i || restart || tick) begin
      pre_r <= 10'h000;
    end else begin
      pre_r <= pre_r + 10'h001;
    end
  end

  // phase counter: high phase then low phase, each in whole units
  always_ff @(posedge clk_i) begin
    if (rst_i || restart) begin
      cnt_r <= 7'h00;
      phase_r <= 1'b1;
    end else if (tick) begin
      if (phase_r && (cnt_r + 7'h01 >= cfg.high_cnt)) begin
        cnt_r <= 7'h00;
        phase_r <= 1'b0;
      end else if (!phase_r && (cnt_r + 7'h01 >= cfg.low_cnt)) begin
        cnt_r <= 7'h00;
        phase_r <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 7'h01;
      end
    end
  end

  // registered drive; zero counts override the toggling
  always_ff @(posedge clk_i) begin
    if (rst_i || !cfg.enable) begin
      pwm_r <= 1'b0;
    end else if (cfg.high_cnt == 7'h00) begin
      pwm_r <= 1'b0;
    end else if (cfg.low_cnt == 7'h00) begin
      pwm_r <= 1'b1;
    end else begin
      pwm_r <= phase_r && !restart;
    end
  end

  assign cfg.pwm = pwm_r;
  assign cfg.phase_high = phase_r;
endmodule : pwm_channel

// ### verification/pwm_enc_asserts.sv
// port assertions for the level pwm encoder
module pwm_enc_asserts (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus and pins
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [1:0] pin_out_o,
  input wire logic [1:0] pin_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic req;
  // request seen on the bus
  assign req = wb_cyc_i && wb_stb_i;
  a_ack_follows_req: assert property (req && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_needs_req: assert property (wb_ack_o |-> $past(req && !wb_ack_o))
    else $error("ack without request");
  a_read_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0)
    else $error("upper read data not zero");
  a_idle_data_holds: assert property (!req |=> $stable(wb_dat_o))
    else $error("read data moved while idle");
  // reset must clear outputs, so this one runs during reset
  a_reset_clears_all: assert property (disable iff (1'b0) rst_i |=>
    (!wb_ack_o && pin_out_o == 2'h0 && pin_oe_o == 2'h0)) else $error("outputs not cleared");
  a_oe_by_write: assert property ($changed(pin_oe_o) |-> $past(wb_ack_o && wb_we_i))
    else $error("enable moved without a write");
  a_input_pin1_quiet: assert property ((!pin_oe_o[1]) [*4] |-> !pin_out_o[1])
    else $error("pin 1 driven while input");
  a_input_pin0_quiet: assert property ((!pin_oe_o[0]) [*4] |-> !pin_out_o[0])
    else $error("pin 0 driven while input");
  // main scenarios reached
  c_write: cover property (req && wb_we_i);
  c_pin1_toggle: cover property ($rose(pin_out_o[1]));
  c_pin0_high: cover property (pin_oe_o[0] && pin_out_o[0]);
endmodule : pwm_enc_asserts

bind gpio_level_pwm_encoder pwm_enc_asserts pwm_enc_asserts_inst (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o));

// ### verification/testbench.sv
// self-checking bench for the level pwm encoder
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, missing_host_detect_i;
  logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o;
  logic [3:0] wb_sel_i;
  logic [1:0] pin_out_o, pin_oe_o;
  logic [15:0] q;
  int fails = 0, n_tests = 0, cyc = 0, hi, lo;
  // device under test
  gpio_level_pwm_encoder gpio_level_pwm_encoder_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .missing_host_detect_i(missing_host_detect_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o));
  // 125 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // hang guard, well above the slowest unit scenario
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // classic single cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] idx, input logic [3:0] sel,
                    input logic [15:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= sel;
    wb_adr_i <= {22'h0, idx, 2'h0};
    wb_dat_i <= {16'h0, d};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    q = wb_dat_o[15:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    wb(1'b1, idx, 4'h3, d);
  endtask : wr
  task automatic rd(input logic [7:0] idx);
    wb(1'b0, idx, 4'h3, 16'h0);
  endtask : rd
  // one full high and low phase of pin 1, from a rising edge
  task automatic width();
    hi = 0;
    lo = 0;
    while (pin_out_o[1] !== 1'b0) @(posedge clk_i);
    while (pin_out_o[1] !== 1'b1) @(posedge clk_i);
    while (pin_out_o[1] === 1'b1) begin
      @(posedge clk_i);
      hi++;
    end
    while (pin_out_o[1] === 1'b0) begin
      @(posedge clk_i);
      lo++;
    end
  endtask : width
  // pin 1 must not move for a long stretch
  task automatic steady(input logic v);
    int bad;
    bad = 0;
    repeat (20) @(posedge clk_i);
    repeat (300) begin
      @(posedge clk_i);
      bad += int'(pin_out_o[1] !== v);
    end
    chk(bad, 0);
  endtask : steady
  task automatic t_regs();
    for (int i = 0; i < 4; i++) begin
      rd(8'h4F + 8'(i));
      chk(q, i[0] ? 16'h3F80 : 16'h007F);
    end
    chk(pin_oe_o, 2'h0);
    wr(8'h50, 16'hFFFF);
    rd(8'h50);
    chk(q, 16'h3FFF);
    wb(1'b1, 8'h51, 4'h1, 16'hC3AA);
    rd(8'h51);
    chk(q, 16'h00AA);
    wr(8'h70, 16'h1234);
    rd(8'h70);
    chk(q, 16'h0);
    $display("test regs done");
  endtask : t_regs
  task automatic t_units();
    for (int s = 0; s < 4; s++) begin
      wr(8'h51, {2'(s), 14'h007F});
      wr(8'h52, {2'h0, 7'h01, 7'h02});
      wr(8'h60, 16'h000A);
      width();
      chk(hi, 16 << (2 * s));
      chk(lo, 32 << (2 * s));
      wr(8'h60, 16'h0000);
    end
    wr(8'h51, {2'h0, 7'h03, 7'h01});
    wr(8'h60, 16'h0002);
    width();
    chk(hi, 48);
    chk(lo, 16);
    $display("test units done");
  endtask : t_units
  task automatic t_static();
    wr(8'h60, 16'h000A);
    wr(8'h52, 16'h0280);
    steady(1'b1);
    wr(8'h52, 16'h0005);
    steady(1'b0);
    wr(8'h52, 16'h0000);
    steady(1'b0);
    wr(8'h52, 16'h0280);
    wr(8'h60, 16'h0008);
    steady(1'b0);
    chk(pin_oe_o, 2'h0);
    $display("test static done");
  endtask : t_static
  task automatic t_detect();
    wr(8'h60, 16'h0001);
    missing_host_detect_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk(pin_out_o[0], 1'b1);
    missing_host_detect_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk(pin_out_o[0], 1'b0);
    missing_host_detect_i <= 1'b1;
    wr(8'h60, 16'h0011);
    repeat (20) @(posedge clk_i);
    chk(pin_out_o[0], 1'b0);
    // detect low so only the high-level pair can raise pin 0
    missing_host_detect_i <= 1'b0;
    wr(8'h50, 16'h0280);
    wr(8'h60, 16'h0015);
    repeat (20) @(posedge clk_i);
    chk(pin_out_o[0], 1'b1);
    rd(8'h61);
    chk(q & 16'h0033, 16'h0011);
    $display("test detect done");
  endtask : t_detect
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize
  // reset for 16 cycles, then the scenarios
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, missing_host_detect_i} = 5'h10;
    {wb_adr_i, wb_dat_i, wb_sel_i} = '0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_units();
    t_static();
    t_detect();
    summarize();
  end
endmodule : testbench
